/* hdl/pmcr_pkg.sv */
// shared constants, tables and types of the command register map
package pmcr_pkg;

  localparam int NSLOT      = 38;
  localparam int CLK_NS     = 20;
  localparam int MS_NS      = 1_000_000;
  localparam int CYC_PER_MS = MS_NS / CLK_NS;

  localparam logic [2:0] STRAP_WAIT = 3'h4;
  localparam logic [5:0] SLOT_NONE  = 6'h3f;

  // send-byte commands
  localparam logic [7:0] C_CLEAR  = 8'h03;
  localparam logic [7:0] C_ST_DEF = 8'h11;
  localparam logic [7:0] C_RS_DEF = 8'h12;
  localparam logic [7:0] C_ST_USR = 8'h15;
  localparam logic [7:0] C_RS_USR = 8'h16;

  // read-only codes
  localparam logic [7:0] C_MODE   = 8'h20;
  localparam logic [7:0] C_SBYTE  = 8'h78;
  localparam logic [7:0] C_SWORD  = 8'h79;
  localparam logic [7:0] C_SVOUT  = 8'h7a;
  localparam logic [7:0] C_SIOUT  = 8'h7b;
  localparam logic [7:0] C_SIN    = 8'h7c;
  localparam logic [7:0] C_STEMP  = 8'h7d;
  localparam logic [7:0] MODE_RST = 8'h13;

  // pin-strap scale factors in 1/1024
  localparam int          K_SHIFT = 10;
  localparam logic [10:0] K_VMAX  = 11'h466;
  localparam logic [10:0] K_MH    = 11'h433;
  localparam logic [10:0] K_ML    = 11'h3cd;
  localparam logic [10:0] K_OVL   = 11'h49a;
  localparam logic [10:0] K_UVL   = 11'h333;
  localparam logic [10:0] K_PG    = 11'h39a;

  // control bit positions
  localparam int CFG_PU  = 4;
  localparam int CFG_CMD = 3;
  localparam int CFG_CPR = 2;
  localparam int CFG_POL = 1;
  localparam int CFG_CPA = 0;
  localparam int OP_ON   = 7;
  localparam logic [1:0] MG_HIGH = 2'h2;
  localparam logic [1:0] MG_LOW  = 2'h1;

  // slots of the writable registers
  localparam int S_OP   = 0;
  localparam int S_CFG  = 1;
  localparam int S_VCMD = 2;
  localparam int S_TRIM = 3;
  localparam int S_CAL  = 4;
  localparam int S_VMAX = 5;
  localparam int S_MH   = 6;
  localparam int S_ML   = 7;
  localparam int S_RATE = 8;
  localparam int S_DUTY = 10;
  localparam int S_FSW  = 11;
  localparam int S_ILV  = 12;
  localparam int S_OVL  = 15;
  localparam int S_OVR  = 16;
  localparam int S_UVL  = 17;
  localparam int S_UVR  = 18;
  localparam int S_OTR  = 22;
  localparam int S_UTR  = 26;
  localparam int S_VIOR = 28;
  localparam int S_VIUR = 32;
  localparam int S_PG   = 33;
  localparam int S_TOND = 34;
  localparam int S_TONR = 35;
  localparam int S_TOFD = 36;
  localparam int S_TOFF = 37;

  localparam logic [7:0] CODES [NSLOT] = '{
    8'h01, 8'h02, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h27, 8'h28,
    8'h32, 8'h33, 8'h37, 8'h38, 8'h39, 8'h40, 8'h41, 8'h44, 8'h45, 8'h46,
    8'h4b, 8'h4f, 8'h50, 8'h51, 8'h52, 8'h53, 8'h54, 8'h55, 8'h56, 8'h57,
    8'h58, 8'h59, 8'h5a, 8'h5e, 8'h60, 8'h61, 8'h64, 8'h65};

  localparam logic [15:0] RSTV [NSLOT] = '{
    16'h0000, 16'h0016, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'hba00, 16'h0000, 16'head6, 16'h0000, 16'h0000, 16'hc2ee,
    16'hb667, 16'h0000, 16'h0080, 16'h0000, 16'h0080, 16'hd340, 16'hd4c0,
    16'hebe8, 16'h0080, 16'heb70, 16'he580, 16'he490, 16'h0080, 16'hd3a0,
    16'h0080, 16'hd360, 16'hca40, 16'hca00, 16'h0080, 16'h0000, 16'hca80,
    16'hca80, 16'hca80, 16'hca80};

  localparam logic [NSLOT-1:0] BYTE_REG = 38'h1_1445_0003;

  typedef enum logic [2:0] {SQ_OFF, SQ_ONDLY, SQ_RISE, SQ_ON, SQ_OFFDLY, SQ_FALL} pmcr_seq_t;

  typedef struct packed {
    logic [NSLOT-1:0][15:0] live;
    logic [NSLOT-1:0][15:0] dflt;
    logic [NSLOT-1:0][15:0] user;
    logic                   init;
    logic [2:0]             ini_cnt;
    pmcr_seq_t              seq;
    logic [31:0]            cnt;
    logic [31:0]            acc;
    logic [15:0]            vref;
    logic                   latched;
    logic                   on;
    logic [7:0]             s_vout;
    logic [7:0]             s_iout;
    logic [7:0]             s_in;
    logic [7:0]             s_temp;
    logic [15:0]            rdata;
    logic                   rvalid;
    logic                   err;
  } pmcr_st_t;

endpackage

/* hdl/pmcr_sync.sv */
// three-stage synchroniser with agreement filter
`timescale 1ns/10ps
module pmcr_sync #(
  parameter int W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_reset,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] o;
  } pmcr_sync_st_t;

  pmcr_sync_st_t q;
  pmcr_sync_st_t d;

  always_comb begin
    d    = q;
    d.s1 = i_async;
    d.s2 = q.s1;
    d.s3 = q.s2;
    // a bit changes only once stages two and three agree
    for (int i = 0; i < W; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        d.o[i] = q.s3[i];
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_sync = q.o;

endmodule

/* hdl/pmcr_top.sv */
// command register map, store levels and output sequencer
`timescale 1ns/10ps
module pmcr_top
  import pmcr_pkg::*;
#(
  parameter int          CYC_MS      = CYC_PER_MS,
  parameter logic [15:0] FSW_DEFAULT = 16'h0000
) (
  input  wire logic        I_CLK,
  input  wire logic        I_RESET,
  input  wire logic        I_CMD_VALID,
  input  wire logic        I_CMD_WRITE,
  input  wire logic [7:0]  I_CMD_CODE,
  input  wire logic [15:0] I_CMD_DATA,
  input  wire logic        I_EN,
  input  wire logic [15:0] I_STRAP_VOUT,
  input  wire logic [6:0]  I_BUS_ADDR,
  input  wire logic        I_VOUT_OV,
  input  wire logic        I_VOUT_UV,
  input  wire logic        I_IOUT_OC,
  input  wire logic        I_IOUT_UC,
  input  wire logic        I_OT,
  input  wire logic        I_UT,
  input  wire logic        I_VIN_OV,
  input  wire logic        I_VIN_UV,
  output logic      [15:0] O_RD_DATA,
  output logic             O_RD_VALID,
  output logic             O_CMD_ERR,
  output logic             O_OUT_ON,
  output logic      [15:0] O_VREF,
  output logic      [15:0] O_DUTY_LIMIT,
  output logic      [15:0] O_PHASE,
  output logic      [15:0] O_FSW
);

  pmcr_st_t    q;
  pmcr_st_t    d;
  logic [23:0] sy;

  pmcr_sync #(
    .W (24)
  ) u_sync (
    .i_clk   (I_CLK),
    .i_reset (I_RESET),
    .i_async ({I_EN, I_BUS_ADDR, I_STRAP_VOUT}),
    .o_sync  (sy)
  );

  // command code to storage slot
  function automatic logic [5:0] slot_of(input logic [7:0] c);
    logic [5:0] s;
    s = SLOT_NONE;
    for (int i = 0; i < NSLOT; i++) begin
      if (CODES[i] == c) begin
        s = 6'(i);
      end
    end
    return s;
  endfunction

  // linear word times a constant, exponent applied as a shift
  function automatic logic [31:0] l11_mul(input logic [15:0] w, input logic [31:0] k);
    logic signed [4:0]  e;
    logic signed [10:0] m;
    logic [63:0]        p;
    int                 sh;
    e  = w[15:11];
    m  = w[10:0];
    sh = int'(e);
    p  = (m < 0) ? 64'h0 : {53'h0, m} * {32'h0, k};
    if (sh < 0) begin
      p = p >> (-sh);
    end else begin
      p = p << sh;
    end
    return p[31:0];
  endfunction

  // strap voltage scaled by a factor in 1/1024
  function automatic logic [15:0] strap_scale(input logic [15:0] v, input logic [10:0] k);
    logic [26:0] p;
    p = {11'h0, v} * {16'h0, k};
    return p[K_SHIFT+15:K_SHIFT];
  endfunction

  // accumulator step: top bit says one lsb is due
  function automatic logic [32:0] ramp(input logic [31:0] acc, input logic [31:0] a,
                                       input logic [31:0] th);
    logic [32:0] s;
    logic [32:0] t;
    t = (th == 32'h0) ? 33'h1 : {1'b0, th};
    s = {1'b0, acc} + {1'b0, a};
    if (s >= t) begin
      return {1'b1, 32'(s - t)};
    end
    return {1'b0, s[31:0]};
  endfunction

  // fault bit seven, low-side fault bit four
  function automatic logic [7:0] flags(input logic hi, input logic lo);
    return {hi, 2'b00, lo, 4'h0};
  endfunction

  always_comb begin
    logic [5:0]  sl;
    logic [15:0] cfg;
    logic [15:0] op;
    logic        pin_on;
    logic        want;
    logic [15:0] base;
    logic [15:0] tgt;
    logic        trip;
    logic        clr;
    logic [32:0] rp;
    logic [31:0] t_ond;
    logic [31:0] t_onr;
    logic [31:0] t_ofd;
    logic [31:0] t_off;
    logic [31:0] rate;
    logic [7:0]  sbyte;
    logic [15:0] v;
    d        = q;
    sl       = slot_of(I_CMD_CODE);
    cfg      = q.live[S_CFG];
    op       = q.live[S_OP];
    clr      = 1'b0;
    rp       = 33'h0;
    v        = sy[15:0];
    sbyte    = {2'b00, q.s_vout[7], q.s_iout[7], q.s_in[4], |q.s_temp, 2'b00};
    d.rvalid = 1'b0;
    d.err    = 1'b0;

    // enable source selection
    pin_on = cfg[CFG_POL] ? sy[23] : ~sy[23];
    want   = ~cfg[CFG_PU] | ((~cfg[CFG_CMD] | op[OP_ON]) & (~cfg[CFG_CPR] | pin_on));

    // effective target, clamped to the ceiling
    if (op[5:4] == MG_HIGH) begin
      base = q.live[S_MH];
    end else if (op[5:4] == MG_LOW) begin
      base = q.live[S_ML];
    end else begin
      base = 16'(q.live[S_VCMD] + q.live[S_TRIM] + q.live[S_CAL]);
    end
    tgt = (base > q.live[S_VMAX]) ? q.live[S_VMAX] : base;

    t_ond = l11_mul(q.live[S_TOND], 32'(CYC_MS));
    t_onr = l11_mul(q.live[S_TONR], 32'(CYC_MS));
    t_ofd = l11_mul(q.live[S_TOFD], 32'(CYC_MS));
    t_off = l11_mul(q.live[S_TOFF], 32'(CYC_MS));
    rate  = l11_mul(q.live[S_RATE], 32'h0000_2000);

    // strap capture once the synchroniser has settled
    if (q.init) begin
      d.ini_cnt = q.ini_cnt + 3'h1;
      if (q.ini_cnt == STRAP_WAIT) begin
        d.init = 1'b0;
        d.live[S_VCMD] = v;
        d.live[S_VMAX] = strap_scale(v, K_VMAX);
        d.live[S_MH]   = strap_scale(v, K_MH);
        d.live[S_ML]   = strap_scale(v, K_ML);
        d.live[S_OVL]  = strap_scale(v, K_OVL);
        d.live[S_UVL]  = strap_scale(v, K_UVL);
        d.live[S_PG]   = strap_scale(v, K_PG);
        d.live[S_ILV]  = {12'h000, sy[19:16]};
        d.live[S_FSW]  = FSW_DEFAULT;
        d.dflt         = d.live;
        d.user         = d.live;
      end
    end

    // command port
    if (I_CMD_VALID && !q.init) begin
      if (I_CMD_WRITE) begin
        case (I_CMD_CODE)
          C_CLEAR:  clr = 1'b1;
          C_ST_DEF: d.dflt = q.live;
          C_RS_DEF: d.live = q.dflt;
          C_ST_USR: d.user = q.live;
          C_RS_USR: d.live = q.user;
          default: begin
            if (sl == SLOT_NONE) begin
              d.err = 1'b1;
            end else if (BYTE_REG[sl]) begin
              d.live[sl] = {8'h00, I_CMD_DATA[7:0]};
            end else begin
              d.live[sl] = I_CMD_DATA;
            end
          end
        endcase
      end else begin
        d.rvalid = 1'b1;
        case (I_CMD_CODE)
          C_MODE:  d.rdata = {8'h00, MODE_RST};
          C_SBYTE: d.rdata = {8'h00, sbyte};
          C_SWORD: d.rdata = {|q.s_vout, |q.s_iout, |q.s_in, 5'h00, sbyte};
          C_SVOUT: d.rdata = {8'h00, q.s_vout};
          C_SIOUT: d.rdata = {8'h00, q.s_iout};
          C_SIN:   d.rdata = {8'h00, q.s_in};
          C_STEMP: d.rdata = {8'h00, q.s_temp};
          default: begin
            if (sl == SLOT_NONE) begin
              d.rdata = 16'h0000;
              d.err   = 1'b1;
            end else begin
              d.rdata = q.live[sl];
            end
          end
        endcase
      end
    end

    // status flags: a new event beats a clear in the same cycle
    d.s_vout = (clr ? 8'h00 : q.s_vout) | flags(I_VOUT_OV, I_VOUT_UV);
    d.s_iout = (clr ? 8'h00 : q.s_iout) | flags(I_IOUT_OC, I_IOUT_UC);
    d.s_in   = (clr ? 8'h00 : q.s_in) | flags(I_VIN_OV, I_VIN_UV);
    d.s_temp = (clr ? 8'h00 : q.s_temp) | flags(I_OT, I_UT);

    // responses with a nonzero action field shut the output
    trip = (I_VOUT_OV && q.live[S_OVR][7:6] != 2'b00) ||
           (I_VOUT_UV && q.live[S_UVR][7:6] != 2'b00) ||
           (I_OT && q.live[S_OTR][7:6] != 2'b00) ||
           (I_UT && q.live[S_UTR][7:6] != 2'b00) ||
           (I_VIN_OV && q.live[S_VIOR][7:6] != 2'b00) ||
           (I_VIN_UV && q.live[S_VIUR][7:6] != 2'b00);

    // output sequencer
    case (q.seq)
      SQ_OFF: begin
        d.vref = 16'h0000;
        if (want && !q.latched && !q.init) begin
          d.seq = SQ_ONDLY;
          d.cnt = t_ond;
        end
      end
      SQ_ONDLY: begin
        if (!want) begin
          d.seq = SQ_OFF;
        end else if (q.cnt == 32'h0) begin
          d.seq = SQ_RISE;
          d.cnt = t_onr;
          d.acc = 32'h0;
        end else begin
          d.cnt = q.cnt - 32'h1;
        end
      end
      SQ_RISE: begin
        rp    = ramp(q.acc, {16'h0, tgt}, t_onr);
        d.acc = rp[31:0];
        if (!want) begin
          d.seq = SQ_OFFDLY;
          d.cnt = t_ofd;
        end else if (q.cnt == 32'h0) begin
          d.seq  = SQ_ON;
          d.vref = tgt;
          d.acc  = 32'h0;
        end else begin
          d.cnt = q.cnt - 32'h1;
          if (rp[32] && q.vref < tgt) begin
            d.vref = q.vref + 16'h1;
          end
        end
      end
      SQ_ON: begin
        rp    = ramp(q.acc, rate, 32'(CYC_MS));
        d.acc = rp[31:0];
        if (rp[32] && q.vref < tgt) begin
          d.vref = q.vref + 16'h1;
        end else if (rp[32] && q.vref > tgt) begin
          d.vref = q.vref - 16'h1;
        end
        if (!want && cfg[CFG_CPA]) begin
          d.seq  = SQ_OFF;
          d.vref = 16'h0000;
        end else if (!want) begin
          d.seq = SQ_OFFDLY;
          d.cnt = t_ofd;
        end
      end
      SQ_OFFDLY: begin
        if (q.cnt == 32'h0) begin
          d.seq = SQ_FALL;
          d.cnt = t_off;
          d.acc = 32'h0;
        end else begin
          d.cnt = q.cnt - 32'h1;
        end
      end
      SQ_FALL: begin
        rp    = ramp(q.acc, {16'h0, tgt}, t_off);
        d.acc = rp[31:0];
        if (q.cnt == 32'h0) begin
          d.seq  = SQ_OFF;
          d.vref = 16'h0000;
        end else begin
          d.cnt = q.cnt - 32'h1;
          if (rp[32] && q.vref != 16'h0000) begin
            d.vref = q.vref - 16'h1;
          end
        end
      end
      default: d.seq = SQ_OFF;
    endcase

    // latched shutdown until the enable is withdrawn
    if (!want) begin
      d.latched = 1'b0;
    end
    if (trip) begin
      d.seq     = SQ_OFF;
      d.vref    = 16'h0000;
      d.latched = 1'b1;
    end
    d.on = (d.seq != SQ_OFF) && (d.seq != SQ_ONDLY);
  end

  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      q      <= '0;
      q.init <= 1'b1;
      q.seq  <= SQ_OFF;
      for (int i = 0; i < NSLOT; i++) begin
        q.live[i] <= RSTV[i];
        q.dflt[i] <= RSTV[i];
        q.user[i] <= RSTV[i];
      end
    end else begin
      q <= d;
    end
  end

  assign O_RD_DATA    = q.rdata;
  assign O_RD_VALID   = q.rvalid;
  assign O_CMD_ERR    = q.err;
  assign O_OUT_ON     = q.on;
  assign O_VREF       = q.vref;
  assign O_DUTY_LIMIT = q.live[S_DUTY];
  assign O_PHASE      = q.live[S_ILV];
  assign O_FSW        = q.live[S_FSW];

endmodule

/* dv/pmcr_top_sva.sv */
// assertions on the command port and the output sequencer
`timescale 1ns/10ps
module pmcr_top_sva (
  input wire logic        I_CLK,
  input wire logic        I_RESET,
  input wire logic        I_CMD_VALID,
  input wire logic        I_CMD_WRITE,
  input wire logic [7:0]  I_CMD_CODE,
  input wire logic [6:0]  I_BUS_ADDR,
  input wire logic [15:0] O_RD_DATA,
  input wire logic        O_RD_VALID,
  input wire logic        O_CMD_ERR,
  input wire logic        O_OUT_ON,
  input wire logic [15:0] O_VREF,
  input wire logic [15:0] O_DUTY_LIMIT,
  input wire logic [15:0] O_PHASE
);
  logic [3:0] n_q;
  logic [3:0] n_d;
  logic       rq;
  logic       rd;
  logic       wr;
  // cycles since reset release, saturating
  always_comb begin
    n_d = (n_q == 4'hf) ? n_q : n_q + 4'h1;
  end
  always_ff @(posedge I_CLK) begin
    n_q <= I_RESET ? 4'h0 : n_d;
  end
  assign rq = I_CMD_VALID && !I_CMD_WRITE;
  assign rd = (n_q >= 4'h8) && rq;
  assign wr = (n_q >= 4'h8) && I_CMD_VALID && I_CMD_WRITE;
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (I_RESET);
  property p_rd_ans;
    rd |=> O_RD_VALID;
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
  property p_rd_only;
    O_RD_VALID |-> $past(rq);
  endproperty
  a_rd_only: assert property (p_rd_only) else $error("answer without read");
  property p_mode;
    rd && I_CMD_CODE == 8'h20 |=> O_RD_DATA == 16'h0013;
  endproperty
  a_mode: assert property (p_mode) else $error("format mode value wrong");
  property p_mode_ro;
    wr && I_CMD_CODE == 8'h20 |=> O_CMD_ERR;
  endproperty
  a_mode_ro: assert property (p_mode_ro) else $error("format mode write taken");
  property p_stat_ro;
    wr && I_CMD_CODE inside {[8'h78:8'h7d]} |=> O_CMD_ERR;
  endproperty
  a_stat_ro: assert property (p_stat_ro) else $error("status write taken");
  property p_duty;
    $fell(I_RESET) |-> O_DUTY_LIMIT == 16'head6;
  endproperty
  a_duty: assert property (p_duty) else $error("duty limit reset wrong");
  property p_phase;
    $fell(I_RESET) |-> ##8 O_PHASE == {12'h000, I_BUS_ADDR[3:0]};
  endproperty
  a_phase: assert property (p_phase) else $error("phase default wrong");
  property p_vref_off;
    !O_OUT_ON |-> O_VREF == 16'h0000;
  endproperty
  a_vref_off: assert property (p_vref_off) else $error("reference while off");
endmodule

bind pmcr_top pmcr_top_sva i_sva (
  .I_CLK, .I_RESET, .I_CMD_VALID, .I_CMD_WRITE, .I_CMD_CODE, .I_BUS_ADDR, .O_RD_DATA,
  .O_RD_VALID, .O_CMD_ERR, .O_OUT_ON, .O_VREF, .O_DUTY_LIMIT, .O_PHASE
);

/* dv/pmcr_host.sv */
// host model issuing command-port transfers
`timescale 1ns/10ps
module pmcr_host (
  input  wire logic        i_clk,
  input  wire logic [15:0] i_rd_data,
  input  wire logic        i_rd_valid,
  input  wire logic        i_cmd_err,
  output logic             o_valid,
  output logic             o_write,
  output logic      [7:0]  o_code,
  output logic      [15:0] o_data
);
  initial begin
    o_valid = 1'b0;
    o_write = 1'b0;
    o_code  = 8'h00;
    o_data  = 16'h0000;
  end
  // one strobe cycle, answer taken 1 ns after the taking edge
  task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                      output logic [15:0] q, output logic e);
    @(posedge i_clk);
    #1;
    o_valid = 1'b1;
    o_write = w;
    o_code  = c;
    o_data  = d;
    @(posedge i_clk);
    #1;
    o_valid = 1'b0;
    o_code  = ~c;
    o_data  = ~d;
    q = (w || i_rd_valid) ? i_rd_data : 16'hxxxx;
    e = i_cmd_err;
  endtask
endmodule

/* dv/pmcr_top_test.sv */
// self-checking bench for the command register map
`timescale 1ns/10ps
module pmcr_top_test;
  logic        clk   = 1'b0;
  logic        rst   = 1'b1;
  logic        en    = 1'b0;
  logic [7:0]  flt   = 8'h00;
  logic [15:0] strap = 16'h2000;
  logic [6:0]  addr  = 7'h2b;
  logic        vld;
  logic        wrt;
  logic [7:0]  code;
  logic [15:0] wdat;
  logic [15:0] rdat;
  logic [15:0] vref;
  logic        rvld;
  logic        err;
  logic        on;
  logic [15:0] duty;
  logic [15:0] phase;
  logic [15:0] fsw;
  logic [15:0] got;
  logic        gerr;
  int          n_errors    = 0;
  int          checks_done = 0;
  localparam logic [23:0] T [43] = '{
    24'h02_0016, 24'h20_0013, 24'h21_2000, 24'h22_0000, 24'h23_0000, 24'h24_2330,
    24'h25_2198, 24'h26_1e68, 24'h27_ba00, 24'h28_0000, 24'h32_ead6, 24'h37_000b,
    24'h38_c2ee, 24'h39_b667, 24'h40_24d0, 24'h41_0080, 24'h44_1998, 24'h45_0080,
    24'h46_d340, 24'h4b_d4c0, 24'h4f_ebe8, 24'h50_0080, 24'h51_eb70, 24'h52_e580,
    24'h53_e490, 24'h54_0080, 24'h55_d3a0, 24'h56_0080, 24'h57_d360, 24'h58_ca40,
    24'h59_ca00, 24'h5a_0080, 24'h5e_1cd0, 24'h60_ca80, 24'h61_ca80, 24'h64_ca80,
    24'h65_ca80, 24'h78_0000, 24'h79_0000, 24'h7a_0000, 24'h7b_0000, 24'h7c_0000,
    24'h7d_0000};

  always #10 clk = ~clk;

  pmcr_top #(.CYC_MS(10)) i_dut (
    .I_CLK(clk), .I_RESET(rst), .I_CMD_VALID(vld), .I_CMD_WRITE(wrt),
    .I_CMD_CODE(code), .I_CMD_DATA(wdat), .I_EN(en), .I_STRAP_VOUT(strap),
    .I_BUS_ADDR(addr), .I_VOUT_OV(flt[0]), .I_VOUT_UV(flt[1]), .I_IOUT_OC(flt[2]),
    .I_IOUT_UC(flt[3]), .I_VIN_OV(flt[4]), .I_VIN_UV(flt[5]), .I_OT(flt[6]),
    .I_UT(flt[7]), .O_RD_DATA(rdat), .O_RD_VALID(rvld), .O_CMD_ERR(err),
    .O_OUT_ON(on), .O_VREF(vref), .O_DUTY_LIMIT(duty), .O_PHASE(phase), .O_FSW(fsw)
  );

  pmcr_host i_host (
    .i_clk(clk), .i_rd_data(rdat), .i_rd_valid(rvld), .i_cmd_err(err),
    .o_valid(vld), .o_write(wrt), .o_code(code), .o_data(wdat)
  );

  task automatic end_of_test;
    if (n_errors == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] g, input logic [15:0] x);
    checks_done++;
    if (g !== x) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, g, x);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic rd(input logic [7:0] c, input logic [15:0] x);
    i_host.xfer(1'b0, c, 16'h0000, got, gerr);
    chk(got, x);
  endtask

  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    i_host.xfer(1'b1, c, d, got, gerr);
  endtask

  task automatic rt(input int i);
    rd(T[i][23:16], T[i][15:0]);
  endtask

  task automatic t_defaults;
    for (int i = 0; i < 11; i++) rt(i);
    for (int i = 11; i < 23; i++) rt(i);
    for (int i = 23; i < 43; i++) rt(i);
  endtask

  task automatic t_access;
    wr(8'h22, 16'h0010);
    rd(8'h22, 16'h0010);
    wr(8'h41, 16'hffc0);
    rd(8'h41, 16'h00c0);
    wr(8'h20, 16'h0000);
    chk(16'(gerr), 16'h0001);
    rd(8'h20, 16'h0013);
    wr(8'h79, 16'h1234);
    chk(16'(gerr), 16'h0001);
    rd(8'h79, 16'h0000);
  endtask

  task automatic t_store;
    wr(8'h27, 16'h1234);
    wr(8'h11, 16'h0000);
    wr(8'h27, 16'h5678);
    wr(8'h15, 16'h0000);
    wr(8'h12, 16'h0000);
    rd(8'h27, 16'h1234);
    wr(8'h16, 16'h0000);
    rd(8'h27, 16'h5678);
  endtask

  task automatic t_pin_seq;
    en = 1'b1;
    cyc(50);
    chk(16'(on), 16'h0000);
    cyc(12);
    chk(16'(on), 16'h0001);
    cyc(60);
    chk(vref, 16'h2010);
    en = 1'b0;
    cyc(50);
    chk(16'(on), 16'h0001);
    cyc(65);
    chk(16'(on), 16'h0000);
  endtask

  task automatic t_margin;
    wr(8'h02, 16'h0019);
    wr(8'h01, 16'h00a0);
    cyc(120);
    chk(vref, 16'h2198);
    wr(8'h01, 16'h0000);
    cyc(1);
    chk(16'(on), 16'h0000);
    chk(vref, 16'h0000);
    wr(8'h02, 16'h0016);
  endtask

  task automatic t_outputs;
    wr(8'h32, 16'hea00);
    chk(duty, 16'hea00);
    wr(8'h37, 16'h0005);
    chk(phase, 16'h0005);
    wr(8'h33, 16'h1234);
    chk(fsw, 16'h1234);
    rd(8'h04, 16'h0000);
    chk(16'(gerr), 16'h0001);
    flt[0] = 1'b1;
    wr(8'h03, 16'h0000);
    flt[0] = 1'b0;
    rd(8'h7a, 16'h0080);
  endtask

  task automatic t_cmd_seq;
    wr(8'h02, 16'h0019);
    wr(8'h01, 16'h0080);
    cyc(50);
    chk(16'(on), 16'h0000);
    cyc(8);
    chk(16'(on), 16'h0001);
    flt[5] = 1'b1;
    cyc(1);
    flt[5] = 1'b0;
    cyc(1);
    chk(16'(on), 16'h0000);
    rd(8'h79, 16'h2008);
    wr(8'h01, 16'h0000);
    wr(8'h02, 16'h0016);
  endtask

  task automatic t_faults;
    for (int k = 0; k < 8; k++) begin
      wr(8'h03, 16'h0000);
      cyc(1);
      flt[k] = 1'b1;
      cyc(1);
      flt[k] = 1'b0;
      rd(8'h7a + 8'(k / 2), k[0] ? 16'h0010 : 16'h0080);
      wr(8'h03, 16'h0000);
      rd(8'h7a + 8'(k / 2), 16'h0000);
    end
  endtask

  initial begin
    repeat (12) @(posedge clk);
    #1;
    rst = 1'b0;
    cyc(10);
    t_defaults();
    t_access();
    t_store();
    t_pin_seq();
    t_margin();
    t_cmd_seq();
    t_faults();
    t_outputs();
    end_of_test();
  end

  // about 670 cycles expected; cut off well beyond
  initial begin
    #200_000;
    n_errors++;
    end_of_test();
  end
endmodule
